// >>> hw/vpa_pkg.sv
// Package for the virtual port window: register offsets, field layout, reset values.
// Assumes a 32-bit AXI4-Lite master and sixteen physical 8-bit ports outside.
`default_nettype none
package vpa_pkg;
  localparam int unsigned NPORT = 16;               // Physical ports reachable
  localparam int unsigned NSLOT = 4;                // Virtual slots
  // Byte addresses, one word per register
  localparam logic [7:0] OFF_DIR   = 8'h00;         // Direction
  localparam logic [7:0] OFF_OUT   = 8'h04;         // Output value
  localparam logic [7:0] OFF_IN    = 8'h08;         // Input value
  localparam logic [7:0] OFF_FLAGS = 8'h0c;         // Pin change flags
  localparam logic [7:0] OFF_MAPA  = 8'h10;         // Map control A
  localparam logic [7:0] OFF_MAPB  = 8'h14;         // Map control B
  localparam logic [7:0] OFF_IRQST = 8'h18;         // Sticky event status
  localparam logic [7:0] OFF_IRQMK = 8'h1c;         // Event mask
  localparam logic [7:0] SLOT_STRIDE = 8'h20;       // Window per slot
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [1:0] FLAG_MASK   = 2'h3;        // Only two live flag bits
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] outv;
    logic [1:0] flags;
  } vpa_port_s;
endpackage
`default_nettype wire

// >>> hw/vpa_top.sv
// Virtual port alias window with the sixteen port register sets behind it.
// Assumes AXI4-Lite master on sys_clk; pins arrive asynchronously.
//
// Local design decision: the AXI4-Lite slave port.
`default_nettype none
// How it works
// - Virtual direction acts on mapped port
// - Virtual output acts on mapped port
// - Virtual input reads mapped synchronised pins
// - Sense match on sourced pin sets flag
// - Writing one clears flag, zero keeps
// - Map registers A and B choose port
// - Four-bit code selects port zero..fifteen
// - A holds slots 1/0, B slots 3/2
module vpa_top (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic [127:0] pin_in,      // Input buffer levels, 8 per port
  input  wire logic [15:0]  int0_event,  // Sense-matched event, source 0
  input  wire logic [15:0]  int1_event,  // Sense-matched event, source 1
  output logic [127:0]      pin_dir,     // Direction per port
  output logic [127:0]      pin_out,     // Output value per port
  output logic [31:0]       port_irq_flags, // Two flags per port
  output logic              irq
);
  localparam int unsigned NP = vpa_pkg::NPORT;
  // Physical register sets
  vpa_pkg::vpa_port_s port_r [NP];
  // Two-stage pin synchroniser; stage one read only by stage two
  logic [127:0] pin_s1_r;
  logic [127:0] pin_s2_r;
  logic [31:0]  ev_s1_r;
  logic [31:0]  ev_s2_r;
  logic [31:0]  ev_d_r;                  // Previous level for edge detect
  // Map control registers
  logic [7:0]   map_a_r;
  logic [7:0]   map_b_r;
  logic [3:0]   irq_st_r;                // Sticky: err, read done, write done, flag set
  logic [3:0]   irq_mk_r;
  // AXI write capture
  logic         aw_have_r;
  logic         w_have_r;
  logic [7:0]   aw_addr_r;
  logic [7:0]   w_data_r;
  logic         w_strb_r;
  logic         bvalid_r;
  logic [1:0]   bresp_r;
  logic         rvalid_r;
  logic [31:0]  rdata_r;
  logic [1:0]   rresp_r;

  // Handshake outputs
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Write decode: slot from upper bits, register from lower
  wire       wr_go    = aw_have_r && w_have_r && !bvalid_r;
  wire [1:0] wr_slot  = aw_addr_r[6:5];
  wire [7:0] wr_reg   = {3'h0, aw_addr_r[4:0]};
  wire       wr_inwin = aw_addr_r < (vpa_pkg::SLOT_STRIDE << 2);
  wire [3:0] wr_port  = wr_slot[1] ? (wr_slot[0] ? map_b_r[7:4] : map_b_r[3:0])
                                   : (wr_slot[0] ? map_a_r[7:4] : map_a_r[3:0]);
  wire       wr_dir   = wr_go && wr_inwin && wr_reg == vpa_pkg::OFF_DIR && w_strb_r;
  wire       wr_out   = wr_go && wr_inwin && wr_reg == vpa_pkg::OFF_OUT && w_strb_r;
  wire       wr_flg   = wr_go && wr_inwin && wr_reg == vpa_pkg::OFF_FLAGS && w_strb_r;
  wire       wr_ina   = wr_go && wr_inwin && wr_reg == vpa_pkg::OFF_IN;
  wire       wr_mapa  = wr_go && aw_addr_r == vpa_pkg::OFF_MAPA && w_strb_r;
  wire       wr_mapb  = wr_go && aw_addr_r == vpa_pkg::OFF_MAPB && w_strb_r;
  wire       wr_ist   = wr_go && aw_addr_r == vpa_pkg::OFF_IRQST;
  wire       wr_imk   = wr_go && aw_addr_r == vpa_pkg::OFF_IRQMK && w_strb_r;
  wire       wr_ok    = (wr_inwin && (wr_reg == vpa_pkg::OFF_DIR || wr_reg == vpa_pkg::OFF_OUT
                         || wr_reg == vpa_pkg::OFF_IN || wr_reg == vpa_pkg::OFF_FLAGS))
                        || aw_addr_r == vpa_pkg::OFF_MAPA || aw_addr_r == vpa_pkg::OFF_MAPB
                        || aw_addr_r == vpa_pkg::OFF_IRQST || aw_addr_r == vpa_pkg::OFF_IRQMK;

  // Read decode
  wire       rd_go    = s_axi_arvalid && s_axi_arready;
  wire [1:0] rd_slot  = s_axi_araddr[6:5];
  wire [7:0] rd_reg   = {3'h0, s_axi_araddr[4:0]};
  wire       rd_inwin = s_axi_araddr < (vpa_pkg::SLOT_STRIDE << 2);
  wire [3:0] rd_port  = rd_slot[1] ? (rd_slot[0] ? map_b_r[7:4] : map_b_r[3:0])
                                   : (rd_slot[0] ? map_a_r[7:4] : map_a_r[3:0]);
  wire [7:0] rd_in    = pin_s2_r[rd_port*8 +: 8];
  logic [31:0] rd_val;
  logic        rd_err;
  logic        rd_ist;
  // Read mux; flag bits above two are zero
  always_comb
  begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    rd_ist = 1'b0;
    if (rd_inwin && rd_reg == vpa_pkg::OFF_DIR)
      rd_val = {24'h0, port_r[rd_port].dir};
    else if (rd_inwin && rd_reg == vpa_pkg::OFF_OUT)
      rd_val = {24'h0, port_r[rd_port].outv};
    else if (rd_inwin && rd_reg == vpa_pkg::OFF_IN)
      rd_val = {24'h0, rd_in};
    else if (rd_inwin && rd_reg == vpa_pkg::OFF_FLAGS)
      rd_val = {30'h0, port_r[rd_port].flags};
    else if (s_axi_araddr == vpa_pkg::OFF_MAPA)
      rd_val = {24'h0, map_a_r};
    else if (s_axi_araddr == vpa_pkg::OFF_MAPB)
      rd_val = {24'h0, map_b_r};
    else if (s_axi_araddr == vpa_pkg::OFF_IRQST)
    begin
      rd_val = {28'h0, irq_st_r};
      rd_ist = 1'b1;
    end
    else if (s_axi_araddr == vpa_pkg::OFF_IRQMK)
      rd_val = {28'h0, irq_mk_r};
    else
      rd_err = 1'b1;
  end

  // Rising edge of a synchronised event sets the flag; a held level sets it once
  wire [31:0] ev_set = ev_s2_r & ~ev_d_r;

  // Synchronisers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ev_s1_r  <= '0;
      ev_s2_r  <= '0;
      ev_d_r   <= '0;
    end
    else
    begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      ev_s1_r  <= {int1_event, int0_event};
      ev_s2_r  <= ev_s1_r;
      ev_d_r   <= ev_s2_r;
    end
  end

  // Physical port registers; map changes never touch them
  for (genvar p = 0; p < NP; p++)
  begin : g_port
    wire       hit = wr_port == 4'(p);
    wire [1:0] set = {ev_set[16+p], ev_set[p]};
    wire [1:0] clr = (wr_flg && hit) ? (w_data_r[1:0] & vpa_pkg::FLAG_MASK) : 2'h0;
    always_ff @(posedge sys_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        port_r[p].dir   <= vpa_pkg::RST_BYTE;
        port_r[p].outv  <= vpa_pkg::RST_BYTE;
        port_r[p].flags <= 2'h0;
      end
      else
      begin
        if (wr_dir && hit)
          port_r[p].dir <= w_data_r;
        if (wr_out && hit)
          port_r[p].outv <= w_data_r;
        port_r[p].flags <= (port_r[p].flags & ~clr) | set;
      end
    end
    assign pin_dir[p*8 +: 8]        = port_r[p].dir;
    assign pin_out[p*8 +: 8]        = port_r[p].outv;
    assign port_irq_flags[p*2 +: 2] = port_r[p].flags;
  end

  // Sticky event bits: any flag set, write done, read done, bus error
  wire [3:0] ev_now = {(wr_go && !wr_ok) || (rd_go && rd_err), rd_go, wr_go, |ev_set};
  assign irq = |(irq_st_r & irq_mk_r);

  // Bus and control registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 8'h00;
      w_strb_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= vpa_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= vpa_pkg::RESP_OKAY;
      map_a_r   <= vpa_pkg::RST_BYTE;
      map_b_r   <= vpa_pkg::RST_BYTE;
      irq_st_r  <= 4'h0;
      irq_mk_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? vpa_pkg::RESP_OKAY : vpa_pkg::RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
      if (rd_go)
      begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_val;
        rresp_r  <= rd_err ? vpa_pkg::RESP_SLVERR : vpa_pkg::RESP_OKAY;
      end
      else if (rvalid_r && s_axi_rready)
        rvalid_r <= 1'b0;
      if (wr_mapa)
        map_a_r <= w_data_r;
      if (wr_mapb)
        map_b_r <= w_data_r;
      if (wr_imk)
        irq_mk_r <= w_data_r[3:0];
      // Read clears; a new event in the same cycle wins
      irq_st_r <= ((rd_go && rd_ist) ? 4'h0 : irq_st_r) | ev_now;
    end
  end

  // Input register is read-only in effect; writes are accepted and dropped
  wire unused_ok = wr_ina | wr_ist;

  chk_flag_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    ev_set[7] |=> port_r[7].flags[0])
    else $error("flag zero not set after event");
  chk_flag_clr: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wr_flg && w_data_r[1] && !ev_set[16 + wr_port]) |=> !port_r[$past(wr_port)].flags[1])
    else $error("flag one not cleared by write of one");
  chk_flag_keep: assert property (@(posedge sys_clk) disable iff (!resetn)
    (port_r[7].flags[0] && !(wr_flg && wr_port == 4'h7 && w_data_r[0])) |=> port_r[7].flags[0])
    else $error("flag lost without clear");
  chk_dir_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_dir |=> port_r[$past(wr_port)].dir == $past(w_data_r))
    else $error("direction not written to mapped port");
  chk_out_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_out |=> port_r[$past(wr_port)].outv == $past(w_data_r))
    else $error("output not written to mapped port");
  chk_in_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rd_go && rd_inwin && rd_reg == vpa_pkg::OFF_IN) |=> s_axi_rdata[7:0] == $past(rd_in))
    else $error("input read mismatch");
  chk_flag_upper: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rvalid_r && $past(rd_go && rd_inwin && rd_reg == vpa_pkg::OFF_FLAGS)) |-> s_axi_rdata[31:2] == 30'h0)
    else $error("flag upper bits not zero");
  chk_map_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wr_mapa && !wr_dir && !wr_out) |=> $stable(port_r[0].dir) && $stable(port_r[0].outv))
    else $error("remap altered port contents");
  chk_map_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_mapa |=> map_a_r == $past(w_data_r))
    else $error("map A not written");
endmodule // vpa_top
`default_nettype wire

// >>> bench/vpa_pins_model.sv
// Far side model: pin levels and sense-matched events of the sixteen ports.
// Assumes the bench calls its tasks just after a rising sys_clk edge.
`default_nettype none
module vpa_pins_model (
  input  wire logic        sys_clk,
  output var logic [127:0] pin_in,     // Levels, 8 per port
  output var logic [15:0]  int0_event, // Source 0 match
  output var logic [15:0]  int1_event  // Source 1 match
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet pins from time zero
  initial
  begin
    pin_in = 128'h0;
    int0_event = 16'h0;
    int1_event = 16'h0;
  end
  // Level pattern of one port
  task automatic drive(input int p, input logic [7:0] v);
    pin_in[8*p +: 8] <= v;
  endtask
  // Match held four cycles so the edge survives the synchroniser
  task automatic fire(input int p, input logic s);
    if (s) int1_event[p] <= 1'b1;
    else int0_event[p] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    int0_event[p] <= 1'b0;
    int1_event[p] <= 1'b0;
  endtask
endmodule // vpa_pins_model
`default_nettype wire

// >>> bench/tb_vpa_top.sv
// Bench for the virtual port window: AXI4-Lite tasks and call sequences.
// Assumes vpa_pkg and the far side model are compiled first.
`default_nettype none
module tb_vpa_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, resetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [127:0] pin_in, pin_dir, pin_out;
  logic [15:0] int0_event, int1_event;
  logic [31:0] port_irq_flags;
  int bad_count = 0, tests_run = 0;
  logic [7:0] codes [4] = '{8'h2, 8'h5, 8'h7, 8'h9}; // Slot targets below
  vpa_top dut (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pin_in, .int0_event, .int1_event, .pin_dir, .pin_out, .port_irq_flags, .irq);
  vpa_pins_model pm (.sys_clk, .pin_in, .int0_event, .int1_event);
  // Free-running 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  // Compare and count
  task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One write; address and data released each when taken
  task automatic wr(logic [7:0] a, logic [7:0] d, output logic [1:0] rs);
    bit ap, wp, bp;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 24'h0, d, 4'h1};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    {ap, wp, bp} = 3'b111;
    while (bp)
    begin
      @(posedge sys_clk);
      // Release by non-blocking write so the slave still sees valid at this edge
      if (ap && s_axi_awready)
      begin
        ap = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready)
      begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid)
      begin
        bp = 0;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  // One read; data and response taken at the rvalid edge
  task automatic rd(logic [7:0] a, output logic [33:0] v);
    bit ap, rp;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    {ap, rp} = 2'b11;
    while (rp)
    begin
      @(posedge sys_clk);
      // Release by non-blocking write so the slave still sees arvalid at this edge
      if (ap && s_axi_arready)
      begin
        ap = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid)
      begin
        rp = 0;
        v = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  // Read and expect an OKAY word
  task automatic rchk(string nm, logic [7:0] a, logic [7:0] e);
    logic [33:0] v;
    rd(a, v);
    chk(nm, {vpa_pkg::RESP_OKAY, 24'h0, e}, v);
  endtask
  // Verdict in one place
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    logic [33:0] v;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rchk("map_a", vpa_pkg::OFF_MAPA, 8'h00);
    rchk("map_b", vpa_pkg::OFF_MAPB, 8'h00);
    rchk("dir0", vpa_pkg::OFF_DIR, 8'h00);
    // Every code through slot 0, then all values back after remaps
    for (int c = 0; c < 16; c++)
    begin
      wr(vpa_pkg::OFF_MAPA, 8'(c), r);
      wr(vpa_pkg::OFF_DIR, 8'h10 + 8'(c), r);
      wr(vpa_pkg::OFF_OUT, 8'ha0 + 8'(c), r);
    end
    for (int c = 0; c < 16; c++)
    begin
      chk("pin_dir", 34'(8'h10 + 8'(c)), 34'(pin_dir[8*c +: 8]));
      chk("pin_out", 34'(8'ha0 + 8'(c)), 34'(pin_out[8*c +: 8]));
      wr(vpa_pkg::OFF_MAPA, 8'(c), r);
      rchk("dir_back", vpa_pkg::OFF_DIR, 8'h10 + 8'(c));
    end
    // Four slots on four ports
    wr(vpa_pkg::OFF_MAPA, 8'h52, r);
    wr(vpa_pkg::OFF_MAPB, 8'h97, r);
    for (int s = 0; s < 4; s++)
    begin
      rchk("slot_dir", 8'(32 * s), 8'h10 + codes[s]);
      rchk("slot_out", 8'(32 * s + 4), 8'ha0 + codes[s]);
    end
    // Input of port 9 through slot 3; writes there do nothing
    pm.drive(9, 8'ha5);
    pm.drive(2, 8'h3c);
    repeat (4) @(posedge sys_clk);
    wr(8'h68, 8'hff, r);
    rchk("in_s3", 8'h68, 8'ha5);
    rchk("in_s0", vpa_pkg::OFF_IN, 8'h3c);
    // Flags of port 7 in slot 2, cleared by ones only
    pm.fire(7, 1'b0);
    pm.fire(7, 1'b1);
    repeat (4) @(posedge sys_clk);
    rchk("flags", 8'h4c, 8'h03);
    chk("irq_flags", 34'h3, 34'(port_irq_flags[15:14]));
    wr(8'h4c, 8'h01, r);
    rchk("flags_w1c", 8'h4c, 8'h02);
    wr(8'h4c, 8'h02, r);
    rchk("flags_clr", 8'h4c, 8'h00);
    // Interrupt raised, masked, cleared
    rd(vpa_pkg::OFF_IRQST, v);
    wr(vpa_pkg::OFF_IRQMK, 8'h01, r);
    chk("irq_idle", 34'h0, 34'(irq));
    pm.fire(2, 1'b0);
    repeat (4) @(posedge sys_clk);
    chk("irq_up", 34'h1, 34'(irq));
    wr(vpa_pkg::OFF_IRQMK, 8'h00, r);
    chk("irq_masked", 34'h0, 34'(irq));
    wr(vpa_pkg::OFF_FLAGS, 8'h01, r);
    rd(vpa_pkg::OFF_IRQST, v);
    wr(vpa_pkg::OFF_IRQMK, 8'h01, r);
    chk("irq_clear", 34'h0, 34'(irq));
    // Unmapped places answer with an error
    rd(8'h80, v);
    chk("rd_unmapped", 34'(vpa_pkg::RESP_SLVERR), 34'(v[33:32]));
    wr(8'h84, 8'h11, r);
    chk("wr_unmapped", 34'(vpa_pkg::RESP_SLVERR), 34'(r));
    wrap_up();
  end
endmodule // tb_vpa_top
`default_nettype wire
